/* bcp_pkg.sv */
`default_nettype none
package bcp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] BCP_IDX_BRIDGE_B_DIV  = 6'h0a;
  localparam logic [5:0] BCP_IDX_BRIDGE_C_DIV  = 6'h0b;
  localparam logic [5:0] BCP_IDX_STATUS        = 6'h0c;
  localparam logic [5:0] BCP_IDX_SYS_BUS_MASK  = 6'h14;
  localparam logic [5:0] BCP_IDX_BRIDGE_A_MASK = 6'h18;
  localparam logic [5:0] BCP_IDX_BRIDGE_B_MASK = 6'h1c;

  // Bus geometry
  localparam int unsigned BCP_ADR_W  = 8;
  localparam int unsigned BCP_IDX_LSB = 2;

  // Field widths; all fields start at bit 0 except the status divider fields
  localparam int unsigned BCP_DIV_W  = 3;
  localparam int unsigned BCP_SYS_W  = 7;
  localparam int unsigned BCP_APBA_W = 7;
  localparam int unsigned BCP_APBB_W = 6;
  localparam int unsigned BCP_CNT_W  = 7;

  // Reset values
  localparam logic [2:0] BCP_DIV_RST  = 3'h0;
  localparam logic [6:0] BCP_SYS_RST  = 7'h7f;
  localparam logic [6:0] BCP_APBA_RST = 7'h7f;
  localparam logic [5:0] BCP_APBB_RST = 6'h3f;

  // System-bus mask bit positions
  localparam int unsigned BCP_SYS_USB    = 6;
  localparam int unsigned BCP_SYS_DMA    = 5;
  localparam int unsigned BCP_SYS_FLASH  = 4;
  localparam int unsigned BCP_SYS_DEBUG  = 3;
  localparam int unsigned BCP_SYS_PORT2  = 2;
  localparam int unsigned BCP_SYS_PORT1  = 1;
  localparam int unsigned BCP_SYS_PORT0  = 0;

  // Status register field positions
  localparam int unsigned BCP_ST_PROT    = 0;
  localparam int unsigned BCP_ST_B_LSB   = 1;
  localparam int unsigned BCP_ST_C_LSB   = 4;

  // Divider domain numbers
  localparam int unsigned BCP_DOM_B = 0;
  localparam int unsigned BCP_DOM_C = 1;
endpackage : bcp_pkg
`default_nettype wire

/* bcp_clock_prescale.sv */
`timescale 1ns/10ps
`default_nettype none
module bcp_clock_prescale
  import bcp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [BCP_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output var  logic [31:0]           wb_dat_o,
  output var  logic                  wb_ack_o,
  input  wire logic                  write_protect,
  output var  logic                  bridge_b_tick,
  output var  logic                  bridge_c_tick,
  output var  logic [BCP_SYS_W-1:0]  sys_bus_clk_en,
  output var  logic [BCP_APBA_W-1:0] bridge_a_clk_en,
  output var  logic [BCP_APBB_W-1:0] bridge_b_clk_en
);

  // Whole state of the block
  typedef struct packed {
    logic [BCP_DIV_W-1:0]            sel_b;
    logic [BCP_DIV_W-1:0]            sel_c;
    logic [BCP_SYS_W-1:0]            sys_mask;
    logic [BCP_APBA_W-1:0]           apba_mask;
    logic [BCP_APBB_W-1:0]           apbb_mask;
    logic [1:0][BCP_CNT_W-1:0]       cnt;
    logic [1:0][BCP_DIV_W-1:0]       act;
    logic [1:0]                      tick;
    logic [BCP_SYS_W-1:0]            sys_en;
    logic [BCP_APBA_W-1:0]           apba_en;
    logic [BCP_APBB_W-1:0]           apbb_en;
    logic                            ack;
    logic [31:0]                     dat;
  } bcp_state_t;

  bcp_state_t state_r;
  bcp_state_t state_nxt;

  // Terminal count mask for a ratio of two to the power of code
  function automatic logic [BCP_CNT_W-1:0] bcp_wrap_mask(input logic [BCP_DIV_W-1:0] code);
    logic [BCP_CNT_W:0] one_hot;
    one_hot = '0;
    one_hot[code] = 1'b1;
    bcp_wrap_mask = BCP_CNT_W'(one_hot - 1'b1);
  endfunction

  // Read-back image of a register; unused bits stay zero
  function automatic logic [31:0] bcp_read(input logic [5:0] idx, input bcp_state_t s, input logic prot);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (idx)
      BCP_IDX_BRIDGE_B_DIV:  w[BCP_DIV_W-1:0] = s.sel_b;
      BCP_IDX_BRIDGE_C_DIV:  w[BCP_DIV_W-1:0] = s.sel_c;
      BCP_IDX_SYS_BUS_MASK:  w[BCP_SYS_W-1:0] = s.sys_mask;
      BCP_IDX_BRIDGE_A_MASK: w[BCP_APBA_W-1:0] = s.apba_mask;
      BCP_IDX_BRIDGE_B_MASK: w[BCP_APBB_W-1:0] = s.apbb_mask;
      BCP_IDX_STATUS: begin
        w[BCP_ST_PROT] = prot;
        w[BCP_ST_B_LSB +: BCP_DIV_W] = s.act[BCP_DOM_B];
        w[BCP_ST_C_LSB +: BCP_DIV_W] = s.act[BCP_DOM_C];
      end
      default: w = 32'h0000_0000;
    endcase
    bcp_read = w;
  endfunction

  logic                  req;
  logic [5:0]            idx;
  logic                  wr_ok;
  logic [BCP_DIV_W-1:0]  code_req;
  logic [BCP_CNT_W-1:0]  wrap;

  // Next-state logic: bus slave, prescalers and gates
  always_comb begin
    state_nxt = state_r;
    code_req  = BCP_DIV_RST;
    wrap      = '0;
    req       = wb_cyc_i & wb_stb_i & ~state_r.ack;
    idx       = wb_adr_i[BCP_ADR_W-1:BCP_IDX_LSB];
    // Only byte lane 0 holds live bits, so it alone enables a write
    wr_ok     = req & wb_we_i & wb_sel_i[0] & ~write_protect;

    // Single-cycle answer, dropped the cycle after
    state_nxt.ack = req;
    if (req) begin
      state_nxt.dat = bcp_read(idx, state_r, write_protect);
    end

    // Register writes keep only the implemented bits
    if (wr_ok) begin
      unique case (idx)
        BCP_IDX_BRIDGE_B_DIV:  state_nxt.sel_b = wb_dat_i[BCP_DIV_W-1:0];
        BCP_IDX_BRIDGE_C_DIV:  state_nxt.sel_c = wb_dat_i[BCP_DIV_W-1:0];
        BCP_IDX_SYS_BUS_MASK:  state_nxt.sys_mask = wb_dat_i[BCP_SYS_W-1:0];
        BCP_IDX_BRIDGE_A_MASK: state_nxt.apba_mask = wb_dat_i[BCP_APBA_W-1:0];
        BCP_IDX_BRIDGE_B_MASK: state_nxt.apbb_mask = wb_dat_i[BCP_APBB_W-1:0];
        default: state_nxt.sel_b = state_r.sel_b;
      endcase
    end

    // Prescalers; a new ratio is adopted only at the wrap, never mid-period
    for (int d = 0; d < 2; d++) begin
      code_req = (d == BCP_DOM_B) ? state_r.sel_b : state_r.sel_c;
      wrap     = bcp_wrap_mask(state_r.act[d]);
      if ((state_r.cnt[d] & wrap) == wrap) begin
        state_nxt.cnt[d]  = '0;
        state_nxt.tick[d] = 1'b1;
        state_nxt.act[d]  = code_req;
      end else begin
        state_nxt.cnt[d]  = BCP_CNT_W'(state_r.cnt[d] + 1'b1);
        state_nxt.tick[d] = 1'b0;
      end
    end

    // Gates: full-rate enables follow the masks as registered levels
    state_nxt.sys_en  = state_r.sys_mask;
    state_nxt.apba_en = state_r.apba_mask;
    // Bridge-B enables are whole tick pulses, so gating cannot slice a phase
    state_nxt.apbb_en = state_nxt.tick[BCP_DOM_B] ? state_r.apbb_mask : '0;
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r           <= '0;
      state_r.sel_b     <= BCP_DIV_RST;
      state_r.sel_c     <= BCP_DIV_RST;
      state_r.sys_mask  <= BCP_SYS_RST;
      state_r.apba_mask <= BCP_APBA_RST;
      state_r.apbb_mask <= BCP_APBB_RST;
      state_r.act       <= {BCP_DIV_RST, BCP_DIV_RST};
      state_r.sys_en    <= BCP_SYS_RST;
      state_r.apba_en   <= BCP_APBA_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state flops
  assign wb_ack_o        = state_r.ack;
  assign wb_dat_o        = state_r.dat;
  assign bridge_b_tick   = state_r.tick[BCP_DOM_B];
  assign bridge_c_tick   = state_r.tick[BCP_DOM_C];
  assign sys_bus_clk_en  = state_r.sys_en;
  assign bridge_a_clk_en = state_r.apba_en;
  assign bridge_b_clk_en = state_r.apbb_en;

endmodule // bcp_clock_prescale
`default_nettype wire

/* bcp_clock_prescale_props.sv */
`timescale 1ns/10ps
`default_nettype none
module bcp_clock_prescale_chk
  import bcp_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        write_protect,
  input wire logic        bridge_b_tick,
  input wire logic        bridge_c_tick,
  input wire logic [6:0]  sys_bus_clk_en,
  input wire logic [6:0]  bridge_a_clk_en,
  input wire logic [5:0]  bridge_b_clk_en
);
  logic       req;
  logic [7:0] gb_r;
  logic [7:0] gc_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Request taken at this edge
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Cycles since last tick; a gap that is not a power of two means a cut phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gb_r <= 8'h01;
      gc_r <= 8'h01;
    end else begin
      gb_r <= bridge_b_tick ? 8'h01 : gb_r + 8'h01;
      gc_r <= bridge_c_tick ? 8'h01 : gc_r + 8'h01;
    end
  end
  sequence wr_s(ix);
    req && wb_we_i && wb_sel_i[0] && !write_protect && wb_adr_i[7:2] == ix;
  endsequence
  AST_DIV_B: assert property (bridge_b_tick |-> (gb_r & (gb_r - 8'h01)) == 8'h00)
    else $error("bridge-B tick gap not a power of two");
  AST_DIV_C: assert property (bridge_c_tick |-> (gc_r & (gc_r - 8'h01)) == 8'h00)
    else $error("bridge-C tick gap not a power of two");
  AST_MAX_GAP: assert property (gb_r <= 8'h80 && gc_r <= 8'h80)
    else $error("tick gap above 128");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:7] == 25'h0)
    else $error("unused read bits set");
  AST_SYS_MASK: assert property (wr_s(BCP_IDX_SYS_BUS_MASK) |-> ##2 {25'h0, sys_bus_clk_en} == ($past(wb_dat_i, 2) & 32'h7f))
    else $error("system-bus enables wrong");
  AST_A_MASK: assert property (wr_s(BCP_IDX_BRIDGE_A_MASK) |-> ##2 {25'h0, bridge_a_clk_en} == ($past(wb_dat_i, 2) & 32'h7f))
    else $error("bridge-A enables wrong");
  AST_B_GATE: assert property (bridge_b_clk_en != 6'h00 |-> bridge_b_tick)
    else $error("bridge-B enable off tick");
  AST_PROTECT: assert property (req && wb_we_i && write_protect |=> $stable(sys_bus_clk_en) [*2])
    else $error("protected write took effect");
endmodule // bcp_clock_prescale_chk
bind bcp_clock_prescale bcp_clock_prescale_chk i_chk (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .write_protect, .bridge_b_tick, .bridge_c_tick, .sys_bus_clk_en,
  .bridge_a_clk_en, .bridge_b_clk_en);
`default_nettype wire

/* tb_bcp_clock_prescale.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_bcp_clock_prescale
  import bcp_pkg::*;
;
  logic        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, write_protect, wb_ack_o, bridge_b_tick, bridge_c_tick;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [6:0]  sys_bus_clk_en, bridge_a_clk_en;
  logic [5:0]  bridge_b_clk_en;
  int          failures = 0, comparisons = 0, g;
  bcp_clock_prescale i_dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .write_protect, .bridge_b_tick, .bridge_c_tick, .sys_bus_clk_en, .bridge_a_clk_en,
    .bridge_b_clk_en);
  // 125 MHz
  always #4 clk = ~clk;
  task close_out;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One classic cycle; held until ack is sampled, read data taken at that edge
  task acc(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      close_out();
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // Divider selections take byte lane 0 only, the masks a whole word
  task rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, (a[7:2] == BCP_IDX_BRIDGE_B_DIV || a[7:2] == BCP_IDX_BRIDGE_C_DIV) ? 4'h1 : 4'hf);
    chk(q, e);
  endtask
  // Cycles to the next tick, seen at the falling edge
  task tk(input bit d);
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while ((d ? bridge_c_tick : bridge_b_tick) !== 1'b1 && g < 300);
    if (g >= 300) begin
      failures++;
      close_out();
    end
  endtask
  // Two ticks flush the old ratio before measuring
  task per(input bit d, input logic [2:0] c);
    acc(1'b1, {d ? BCP_IDX_BRIDGE_C_DIV : BCP_IDX_BRIDGE_B_DIV, 2'b00}, {29'h0, c}, 4'h1);
    repeat (3) tk(d);
    chk(32'(g), 32'h1 << c);
  endtask
  logic [7:0]  ad [5] = '{8'h28, 8'h2c, 8'h50, 8'h60, 8'h70};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h7f, 32'h7f, 32'h3f};
  logic [31:0] wv [5] = '{32'hfd, 32'hfa, 32'hffffffb5, 32'hffffff4a, 32'hffffffe5};
  logic [31:0] mv [5] = '{32'h5, 32'h2, 32'h35, 32'h4a, 32'h25};
  initial begin
    {clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, write_protect, wb_adr_i, wb_sel_i, wb_dat_i} <= '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    // Reset values, then ones into unused bits
    for (int i = 0; i < 5; i++) begin
      rd(ad[i], rv[i]);
      acc(1'b1, ad[i], wv[i], i < 2 ? 4'h1 : 4'hf);
      rd(ad[i], mv[i]);
    end
    repeat (2) @(negedge clk);
    chk({25'h0, sys_bus_clk_en}, 32'h35);
    chk({25'h0, bridge_a_clk_en}, 32'h4a);
    tk(1'b0);
    chk({26'h0, bridge_b_clk_en}, 32'h25);
    for (int d = 0; d < 2; d++) for (int c = 0; c < 8; c++) per(d[0], c[2:0]);
    @(posedge clk);
    write_protect <= 1'b1;
    acc(1'b1, {BCP_IDX_SYS_BUS_MASK, 2'b00}, 32'h0, 4'hf);
    rd({BCP_IDX_SYS_BUS_MASK, 2'b00}, 32'h35);
    rd({BCP_IDX_STATUS, 2'b00}, 32'h7f);
    rd(8'hfc, 32'h0);
    close_out();
  end
endmodule // tb_bcp_clock_prescale
`default_nettype wire
